// File: logic/flash_host.sv
/*
  host-side controller driving a parallel nor flash through its control pins.
  assumes the user holds req until ack and that pin inputs are synchronous to clk.
*/
// Notes on behaviour
// - read only with select and output enable low, strobe and reset high.
// - write only with select and strobe low, output enable and reset high.
// - host waits read recovery after reset release before reading.
// - host waits write recovery after reset release before writing.
// - after abort, recovery delays count from end of shutdown.
// - reset pin follows the system reset driving the processor.
`timescale 1ns/100ps
`include "flash_host_defines.svh"

module flash_host #(
  parameter int AW             = 20,                  // flash word address width
  parameter int DW             = 16,                  // data width
  parameter int ABORT_WAIT_CYC = `ABORT_SHUTDOWN_NS / `CLK_PERIOD_NS // abort shutdown, cycles
) (
  input  wire logic          clk,         // 100 MHz clock
  input  wire logic          arst_n,      // async reset, low active
  input  wire logic          sys_reset_n, // processor reset, low active
  input  wire logic          busy_op,     // user: program/erase may be running
  input  wire logic          req,         // access request, level
  input  wire logic          req_write,   // 1 write, 0 read
  input  wire logic [AW-1:0] req_addr,    // word address
  input  wire logic [DW-1:0] req_wdata,   // write data
  output logic               ack,         // one-cycle done pulse
  output logic      [DW-1:0] rdata,       // read data, held
  output logic               ready,       // recovery done, accesses allowed
  output logic      [AW-1:0] addr,        // flash address pins
  output logic               chip_select_n,          // flash select
  output logic               output_drive_enable_n,  // flash output enable
  output logic               write_strobe_n,         // flash write strobe
  output logic               reset_powerdown_n,      // flash reset
  input  wire logic [DW-1:0] data_lines_i, // data pins in
  output logic      [DW-1:0] data_lines_o, // data pins out
  output logic               data_lines_oe // high while host drives data
);

  localparam int RD_CYC  = (`ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 1;
  localparam int WR_CYC  = (`WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int SU_CYC  = (`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int RRC     = (`READ_RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int WRC     = (`WRITE_RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int REC_CYC = (RRC > WRC) ? RRC : WRC;

  flash_host_pkg::host_state_t state_reg;
  logic [`CNT_W-1:0]           cnt_reg;
  logic                        op_write_reg;
  logic [`CNT_W-1:0]           low_cnt_reg;  // check helper: reset pin low cycles

  //////////////////////////////////////////////////////////////////////////////
  // sequencer: reset, abort wait, recovery, then read/write cycles
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg    <= flash_host_pkg::ST_RESET;
      // power-on gets the full pulse too, not just the arst time
      cnt_reg      <= `CNT_W'(`RESET_LOW_CYC);
      op_write_reg <= 1'b0;
    end else begin
      if (!sys_reset_n) begin
        // an operation may be in flight: wait the full shutdown first
        state_reg <= busy_op ? flash_host_pkg::ST_ABORT : flash_host_pkg::ST_RESET;
        cnt_reg   <= busy_op ? `CNT_W'(ABORT_WAIT_CYC) : `CNT_W'(`RESET_LOW_CYC);
      end else begin
        unique case (state_reg)
          flash_host_pkg::ST_ABORT: begin
            // recovery is measured from end of shutdown, not pin rise
            if (cnt_reg > `CNT_ONE) cnt_reg <= cnt_reg - `CNT_ONE;
            else begin
              state_reg <= flash_host_pkg::ST_RECOVER;
              cnt_reg   <= `CNT_W'(REC_CYC);
            end
          end
          flash_host_pkg::ST_RESET: begin
            // pin stays low for the full pulse time before release
            if (cnt_reg > `CNT_ONE) cnt_reg <= cnt_reg - `CNT_ONE;
            else begin
              state_reg <= flash_host_pkg::ST_RECOVER;
              cnt_reg   <= `CNT_W'(REC_CYC);
            end
          end
          flash_host_pkg::ST_RECOVER: begin
            if (cnt_reg > `CNT_ONE) cnt_reg <= cnt_reg - `CNT_ONE;
            else state_reg <= flash_host_pkg::ST_IDLE;
          end
          flash_host_pkg::ST_IDLE: begin
            if (req && !ack) begin
              state_reg    <= flash_host_pkg::ST_SETUP;
              op_write_reg <= req_write;
              cnt_reg      <= `CNT_W'(SU_CYC);
            end
          end
          flash_host_pkg::ST_SETUP: begin
            if (cnt_reg > `CNT_ONE) cnt_reg <= cnt_reg - `CNT_ONE;
            else begin
              state_reg <= op_write_reg ? flash_host_pkg::ST_WRITE : flash_host_pkg::ST_READ;
              cnt_reg   <= op_write_reg ? `CNT_W'(WR_CYC) : `CNT_W'(RD_CYC);
            end
          end
          flash_host_pkg::ST_READ, flash_host_pkg::ST_WRITE: begin
            if (cnt_reg > `CNT_ONE) cnt_reg <= cnt_reg - `CNT_ONE;
            else state_reg <= flash_host_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control pins; only the two legal strobe pairs are ever driven low
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reset_powerdown_n     <= 1'b0;
      chip_select_n         <= 1'b1;
      output_drive_enable_n <= 1'b1;
      write_strobe_n        <= 1'b1;
      ready                 <= 1'b0;
    end else begin
      // pin low for the whole reset count and the whole abort wait
      reset_powerdown_n <= sys_reset_n &&
        state_reg != flash_host_pkg::ST_RESET &&
        state_reg != flash_host_pkg::ST_ABORT;
      // deselect is never an abort: a busy device simply carries on
      chip_select_n <= !(sys_reset_n && (state_reg == flash_host_pkg::ST_READ ||
                                         state_reg == flash_host_pkg::ST_WRITE));
      output_drive_enable_n <= !(sys_reset_n && state_reg == flash_host_pkg::ST_READ);
      // strobe rises one cycle before select; address and data held past it
      write_strobe_n <= !(sys_reset_n && state_reg == flash_host_pkg::ST_WRITE &&
                          cnt_reg > `CNT_ONE);
      ready <= sys_reset_n && state_reg == flash_host_pkg::ST_IDLE;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // address, data drive and response
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr          <= '0;
      data_lines_o  <= '0;
      data_lines_oe <= 1'b0;
      rdata         <= '0;
      ack           <= 1'b0;
    end else begin
      ack <= 1'b0;
      if (state_reg == flash_host_pkg::ST_IDLE && req && !ack && sys_reset_n) begin
        addr         <= req_addr;
        data_lines_o <= req_wdata;
      end
      // drive only in write-related states, never overlapping a read
      data_lines_oe <= sys_reset_n && op_write_reg &&
                       (state_reg == flash_host_pkg::ST_SETUP ||
                        state_reg == flash_host_pkg::ST_WRITE);
      if (sys_reset_n && cnt_reg == `CNT_ONE &&
          (state_reg == flash_host_pkg::ST_READ || state_reg == flash_host_pkg::ST_WRITE)) begin
        ack <= 1'b1;
        if (state_reg == flash_host_pkg::ST_READ) rdata <= data_lines_i;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // check helper: cycles the reset pin has been low, saturating
  // a repetition cannot span the long abort wait, so count instead
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      low_cnt_reg <= '0;
    end else if (reset_powerdown_n) begin
      low_cnt_reg <= '0;
    end else if (low_cnt_reg != '1) begin
      low_cnt_reg <= low_cnt_reg + `CNT_ONE;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  a_no_illegal_mix: assert property (@(posedge clk) disable iff (!arst_n)
    !(!write_strobe_n && !output_drive_enable_n)) else $error("strobe and output enable both low");
  a_no_bus_contend: assert property (@(posedge clk) disable iff (!arst_n)
    !(data_lines_oe && !output_drive_enable_n)) else $error("host drives during read");
  a_write_drive: assert property (@(posedge clk) disable iff (!arst_n)
    !write_strobe_n |=> data_lines_oe) else $error("data dropped at strobe rise");
  a_access_reset: assert property (@(posedge clk) disable iff (!arst_n)
    !chip_select_n |-> reset_powerdown_n) else $error("access during reset");
  a_reset_width: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(reset_powerdown_n) |-> !reset_powerdown_n [*8]) else $error("reset pulse too short");
  a_read_recov: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(reset_powerdown_n) |-> chip_select_n [*8]) else $error("access before recovery");
  a_write_recov: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(reset_powerdown_n) |-> write_strobe_n [*8]) else $error("write before recovery");
  // the whole low time, also through an abort wait
  a_reset_long: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(reset_powerdown_n) |-> low_cnt_reg >= `CNT_W'(`RESET_LOW_CYC))
    else $error("reset pulse below minimum");
  // the pin must not rise while the device still shuts down
  a_abort_hold: assert property (@(posedge clk) disable iff (!arst_n)
    state_reg == flash_host_pkg::ST_ABORT |=> !reset_powerdown_n) else $error("reset released during shutdown");

  // each bus state is driven complete, never a mix of two
  a_write_shape: assert property (@(posedge clk) disable iff (!arst_n)
    !write_strobe_n |-> !chip_select_n && output_drive_enable_n && reset_powerdown_n && data_lines_oe)
    else $error("incomplete write pin state");
  a_read_shape: assert property (@(posedge clk) disable iff (!arst_n)
    !output_drive_enable_n |-> !chip_select_n && write_strobe_n && reset_powerdown_n && !data_lines_oe)
    else $error("incomplete read pin state");
  a_standby_quiet: assert property (@(posedge clk) disable iff (!arst_n)
    chip_select_n |-> output_drive_enable_n && write_strobe_n) else $error("strobe low while deselected");
  // idle means the bus is parked: deselected and not driven
  a_ready_quiet: assert property (@(posedge clk) disable iff (!arst_n)
    ready |-> chip_select_n && !data_lines_oe) else $error("bus active while ready");
  // the device latches at strobe rise: select, address and data still hold
  a_capture_hold: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(write_strobe_n) && reset_powerdown_n |-> !chip_select_n && data_lines_oe && $stable(addr) &&
    $stable(data_lines_o)) else $error("write data moved at strobe rise");

endmodule : flash_host

// File: shared/flash_host_defines.svh
/*
  timing and width constants for the parallel flash host controller.
  assumes a 100 MHz system clock; device timing figures in ns.
*/
`ifndef FLASH_HOST_DEFINES_SVH
`define FLASH_HOST_DEFINES_SVH

`define CLK_PERIOD_NS      10
`define RESET_LOW_NS       100
`define RESET_LOW_CYC      ((`RESET_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_RECOVERY_NS   150
`define WRITE_RECOVERY_NS  150
`define ACCESS_NS          70
`define WRITE_PULSE_NS     50
`define SETUP_NS           20
`define ABORT_SHUTDOWN_NS  22000
`define CNT_W              16
`define CNT_ONE            16'h0001

`endif

// File: shared/flash_host_pkg.sv
/*
  types for the parallel flash host controller.
  assumes nothing beyond the defines header.
*/
package flash_host_pkg;
  typedef enum logic [2:0] {
    ST_RESET,     // reset_powerdown_n held low
    ST_ABORT,     // waiting out the abort shutdown interval
    ST_RECOVER,   // recovery delay after release
    ST_IDLE,      // standby, all strobes high
    ST_SETUP,     // address/data settle before strobe
    ST_READ,      // select and output enable low
    ST_WRITE      // select and write strobe low
  } host_state_t;
endpackage : flash_host_pkg

// File: tb/flash_dev_model.sv
/*
  behavioural model of the parallel flash device on the far side of the host.
  assumes a host that holds address and data across each strobe.
*/
`timescale 1ns/100ps
module flash_dev_model (
  input  wire logic [19:0] addr,                  // word address
  input  wire logic        chip_select_n,         // select
  input  wire logic        output_drive_enable_n, // output enable
  input  wire logic        write_strobe_n,        // write strobe
  input  wire logic        reset_powerdown_n,     // reset pin
  input  wire logic [15:0] dq_in,                 // data from host
  output logic      [15:0] dq_out,                // data to host
  output logic             dq_oe                  // high while driving
);
  logic [15:0] mem [logic [19:0]];
  logic [15:0] last_q = 16'h0000;
  logic        wr_act;
  // erased words read back all ones; reset leaves read-array mode
  function automatic logic [15:0] rd(input logic [19:0] a);
    return mem.exists(a) ? mem[a] : 16'hffff;
  endfunction : rd
  ////////////////////////////////////////////////////////////////////////
  // drive only in the read state, floating otherwise
  assign dq_oe = reset_powerdown_n && !chip_select_n && !output_drive_enable_n && write_strobe_n;
  assign wr_act = reset_powerdown_n && !chip_select_n && !write_strobe_n && output_drive_enable_n;
  // released lines show the inverse so stale values never pass
  always @* if (dq_oe) last_q = rd(addr);
  assign dq_out = dq_oe ? rd(addr) : ~last_q;
  // latch on the first rising strobe or select, at any address
  always @(negedge wr_act) begin
    if (reset_powerdown_n) mem[addr] = dq_in;
  end
endmodule : flash_dev_model

// File: tb/flash_bus_control_and_reset_tb.sv
/*
  self-checking bench for the flash host controller.
  assumes the device model file is compiled first.
*/
`timescale 1ns/100ps
module flash_bus_control_and_reset_tb;
  logic clk, arst_n, sys_reset_n, busy_op, req, req_write, ack, ready, dev_oe;
  logic chip_select_n, output_drive_enable_n, write_strobe_n, reset_powerdown_n, data_lines_oe;
  logic [19:0] req_addr, addr;
  logic [15:0] req_wdata, rdata, data_lines_o, dev_q, data_lines_i;
  logic [15:0] exp_mem [logic [19:0]];
  logic [31:0] seed = 32'h898bca15;
  int failures = 0;
  int check_count = 0;
  // host wins the wire only while it enables its drivers
  assign data_lines_i = data_lines_oe ? data_lines_o : dev_q;
  flash_host #(.ABORT_WAIT_CYC(50)) flash_host_i (.clk(clk), .arst_n(arst_n), .sys_reset_n(sys_reset_n),
    .busy_op(busy_op), .req(req), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .ack(ack), .rdata(rdata), .ready(ready), .addr(addr), .chip_select_n(chip_select_n),
    .output_drive_enable_n(output_drive_enable_n), .write_strobe_n(write_strobe_n),
    .reset_powerdown_n(reset_powerdown_n), .data_lines_i(data_lines_i), .data_lines_o(data_lines_o),
    .data_lines_oe(data_lines_oe));
  flash_dev_model flash_dev_model_i (.addr(addr), .chip_select_n(chip_select_n),
    .output_drive_enable_n(output_drive_enable_n), .write_strobe_n(write_strobe_n),
    .reset_powerdown_n(reset_powerdown_n), .dq_in(data_lines_i), .dq_out(dev_q), .dq_oe(dev_oe));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [15:0] exp_rd(input logic [19:0] a);
    return exp_mem.exists(a) ? exp_mem[a] : 16'hffff;
  endfunction : exp_rd
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      failures++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk
  task automatic summarize;
    if (failures == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  // hold the request until the one-cycle ack, then drop it off-edge
  task automatic acc(input logic w, input logic [19:0] a, input logic [15:0] d);
    int n;
    @(negedge clk);
    {req, req_write, req_addr, req_wdata} = {1'b1, w, a, d};
    n = 0;
    while (ack !== 1'b1 && n < 100) begin @(posedge clk); #1 n++; end
    chk(n < 100, "no ack");
    @(negedge clk) req = 1'b0;
    if (w) exp_mem[a] = d;
    else chk(rdata === exp_rd(a), "read data");
  endtask : acc
  task automatic wait_pin(input logic lvl, output int n);
    n = 0;
    while ((lvl ? ready : reset_powerdown_n) !== lvl && n < 500) begin @(posedge clk); #1 n++; end
  endtask : wait_pin
  // a reset pulse, as an abort when busy, measured at the pins
  task automatic rst_chk(input logic b);
    int lo, rc;
    @(negedge clk) {sys_reset_n, busy_op} = {1'b0, b};
    @(negedge clk) sys_reset_n = 1'b1;
    wait_pin(1'b0, lo);
    lo = 0;
    while (reset_powerdown_n !== 1'b1 && lo < 500) begin @(posedge clk); #1 lo++; end
    busy_op = 1'b0;
    wait_pin(1'b1, rc);
    chk(lo >= (b ? 50 : 10) && lo < 500, "reset pulse length");
    chk(rc >= 15 && rc < 500, "recovery before ready");
  endtask : rst_chk
  ////////////////////////////////////////////////////////////////////////
  // strobe and output enable never low together, data lines never driven by both sides
  always @(posedge clk) begin
    if (arst_n && !write_strobe_n && !output_drive_enable_n) chk(1'b0, "strobe and enable low");
    if (data_lines_oe && dev_oe) chk(1'b0, "data line contention");
  end
  initial begin
    #200000 failures++;
    summarize();
  end
  initial begin
    int n;
    {arst_n, sys_reset_n, busy_op, req, req_write, req_addr, req_wdata} = {3'b010, 2'b00, 36'h0};
    repeat (4) @(posedge clk);
    @(negedge clk) arst_n = 1'b1;
    wait_pin(1'b1, n);
    chk(n < 500, "ready after reset");
    acc(1'b0, 20'h00000, 16'h0000);
    acc(1'b1, 20'h00000, 16'ha5c3);
    acc(1'b1, 20'hfffff, 16'h0000);
    acc(1'b0, 20'hfffff, 16'h0000);
    acc(1'b0, 20'h00000, 16'h0000);
    repeat (12) begin
      seed = lfsr(seed);
      acc(1'b1, seed[19:0], seed[31:16]);
      acc(1'b0, seed[19:0], 16'h0000);
    end
    rst_chk(1'b0);
    acc(1'b0, 20'h00000, 16'h0000);
    rst_chk(1'b1);
    acc(1'b0, seed[19:0], 16'h0000);
    summarize();
  end
endmodule : flash_bus_control_and_reset_tb
